// ===== pkg/bfist_map.vh
// register map, field positions and codes of the bit-field unit
// assumes: included by the design files and the testbench of the bit-field unit
`ifndef BFIST_MAP_VH
`define BFIST_MAP_VH

// register byte offsets on the 32-bit register bus
`define BFIST_CTRL_OFS    8'h00
`define BFIST_STAT_OFS    8'h04
`define BFIST_OPW_OFS     8'h08
`define BFIST_EXT_OFS     8'h0C
`define BFIST_CCR_OFS     8'h10
`define BFIST_OPHI_OFS    8'h14
`define BFIST_OPLO_OFS    8'h18
`define BFIST_DISP_OFS    8'h1C
`define BFIST_EACL_OFS    8'h20
`define BFIST_DREG_OFS    8'h40

// reset values
`define BFIST_RST_WORD    32'h00000000
`define BFIST_RST_CCR     5'h00

// control and status bit positions
`define BFIST_CTRL_GO     0
`define BFIST_STAT_BUSY   0
`define BFIST_STAT_DONE   1
`define BFIST_STAT_ILL    2

// condition code bit positions (x n z v c)
`define BFIST_CC_X        4
`define BFIST_CC_N        3
`define BFIST_CC_Z        2
`define BFIST_CC_V        1
`define BFIST_CC_C        0

// opcode word bits 15..6 for the three operations
`define BFIST_OPC_INS     10'h3BF
`define BFIST_OPC_SET     10'h3BB
`define BFIST_OPC_TST     10'h3A3

// extension word fields
`define BFIST_EXT_SRC_HI  14
`define BFIST_EXT_SRC_LO  12
`define BFIST_EXT_OFSEL   11
`define BFIST_EXT_OFF_HI  10
`define BFIST_EXT_OFF_LO  6
`define BFIST_EXT_WDSEL   5
`define BFIST_EXT_WID_HI  4
`define BFIST_EXT_WID_LO  0

// operand location classes
`define BFIST_EA_DREG     3'h0
`define BFIST_EA_IND      3'h1
`define BFIST_EA_DISP     3'h2
`define BFIST_EA_IDX      3'h3
`define BFIST_EA_ABSW     3'h4
`define BFIST_EA_ABSL     3'h5
`define BFIST_EA_PCREL    3'h6
`define BFIST_EA_BAD      3'h7

// axi response codes
`define BFIST_RESP_OKAY   2'h0
`define BFIST_RESP_SLVERR 2'h2

`endif

// ===== core/bfist_spec.v
// field offset and width decode from the extension word
// assumes: register values already fetched by the caller
`timescale 1ns/1ps
`include "bfist_map.vh"

module bfist_spec (
    input  wire [15:0] ext,
    input  wire [31:0] off_val,
    input  wire [31:0] wid_val,
    output reg  [31:0] offset,
    output reg  [5:0]  width,
    output reg         reserved_bad
);
    reg [4:0] wcode;

    // offset immediate or signed register value, width code 0 means 32
    always @* begin
        if (ext[`BFIST_EXT_OFSEL]) begin
            offset = off_val;
        end else begin
            offset = {27'h0000000, ext[`BFIST_EXT_OFF_HI:`BFIST_EXT_OFF_LO]};
        end
        if (ext[`BFIST_EXT_WDSEL]) begin
            wcode = wid_val[4:0];
        end else begin
            wcode = ext[`BFIST_EXT_WID_HI:`BFIST_EXT_WID_LO];
        end
        width = (wcode == 5'h00) ? 6'h20 : {1'b0, wcode};
        // register selects need their neighbouring bits at zero
        reserved_bad = (ext[`BFIST_EXT_OFSEL] && (ext[10:9] != 2'h0)) ||
                       (ext[`BFIST_EXT_WDSEL] && (ext[4:3] != 2'h0));
    end
endmodule

// ===== core/bfist_field.v
// bit field locate, extract and merge over a 64-bit window
// assumes: start below 32, width 1 to 32, bit 63 is the field origin
`timescale 1ns/1ps

module bfist_field (
    input  wire [63:0] window,
    input  wire [5:0]  start,
    input  wire [5:0]  width,
    input  wire [31:0] value,
    output reg  [31:0] field_lj,
    output reg  [31:0] value_lj,
    output reg  [63:0] mask,
    output reg  [63:0] merged
);
    integer   i;
    reg [5:0] idx;

    // walk the field from its first bit, msb first
    always @* begin
        idx = 6'h00;
        value_lj = value << (6'h20 - width);
        field_lj = 32'h00000000;
        mask = 64'h0000000000000000;
        merged = window;
        for (i = 0; i < 32; i = i + 1) begin
            idx = 6'h3F - start - i[5:0];
            if (i < width) begin
                field_lj[31-i] = window[idx];
                mask[idx] = 1'b1;
                merged[idx] = value_lj[31-i];
            end
        end
    end
endmodule

// ===== core/bfist_core.v
// bit-field insert, test-and-set and test unit with an axi4-lite slave
// assumes: software loads words, operand and data registers, then sets go
//
// Functional notes
// - insert copies the low width bits of the source register into the field
// - insert flags come from the inserted value, not the old field
// - set takes flags from the old field, then fills the field with ones
// - test only updates flags; the operand is left as it was
// - a field is a start offset and a count of consecutive bits
// - n is the field msb, v and c clear, x kept, for all three
// - z is set when every field bit is zero
// - offset select 0 takes an unsigned 0..31 immediate offset
// - offset select 1 reads register ext bits 8-6; bits 10-9 must be zero
// - a register offset is a full signed 32-bit value
// - immediate width codes 1..31 are that width, code 0 is 32 bits
// - register width is taken modulo 32, residue 0 meaning 32 bits
// - width register from ext bits 2-0; bits 4-3 must be zero
// - insert and set accept only data register or control alterable modes
// - location from mode/register: 000,010,101,110,111 with 000 to 011
// - insert source register is ext bits 14-12
`timescale 1ns/1ps
`include "bfist_map.vh"

module bfist_core #(
    parameter AW = 8
) (
    input  wire          MCLK,
    input  wire          RST,
    input  wire [AW-1:0] AWADDR,
    input  wire          AWVALID,
    output reg           AWREADY,
    input  wire [31:0]   WDATA,
    input  wire [3:0]    WSTRB,
    input  wire          WVALID,
    output reg           WREADY,
    output reg  [1:0]    BRESP,
    output reg           BVALID,
    input  wire          BREADY,
    input  wire [AW-1:0] ARADDR,
    input  wire          ARVALID,
    output reg           ARREADY,
    output reg  [31:0]   RDATA,
    output reg  [1:0]    RRESP,
    output reg           RVALID,
    input  wire          RREADY
);
    localparam S_IDLE = 1'b0;
    localparam S_EXEC = 1'b1;

    reg          state;
    reg          aw_got;
    reg          w_got;
    reg [AW-1:0] waddr;
    reg [31:0]   wdata_q;
    reg [3:0]    wstrb_q;
    reg [31:0]   opw;
    reg [31:0]   extw;
    reg [4:0]    ccr;
    reg [31:0]   oper_hi;
    reg [31:0]   oper_lo;
    reg [31:0]   disp;
    reg [2:0]    ea_last;
    reg          done;
    reg          ill;
    reg [31:0]   dreg [0:7];

    wire [31:0] offset;
    wire [5:0]  width;
    wire        reserved_bad;
    wire [31:0] field_lj;
    wire [31:0] value_lj;
    wire [63:0] mask;
    wire [63:0] merged;

    // opcode word class: 0 none, 1 insert, 2 set, 3 test
    function [1:0] op_kind;
        input [15:0] w;
        begin
            case (w[15:6])
                `BFIST_OPC_INS: op_kind = 2'h1;
                `BFIST_OPC_SET: op_kind = 2'h2;
                `BFIST_OPC_TST: op_kind = 2'h3;
                default:        op_kind = 2'h0;
            endcase
        end
    endfunction

    // operand location class from mode and register fields
    function [2:0] ea_class;
        input [2:0] mode;
        input [2:0] rnum;
        begin
            case (mode)
                3'h0: ea_class = `BFIST_EA_DREG;
                3'h2: ea_class = `BFIST_EA_IND;
                3'h5: ea_class = `BFIST_EA_DISP;
                3'h6: ea_class = `BFIST_EA_IDX;
                3'h7: begin
                    case (rnum)
                        3'h0:    ea_class = `BFIST_EA_ABSW;
                        3'h1:    ea_class = `BFIST_EA_ABSL;
                        3'h2:    ea_class = `BFIST_EA_PCREL;
                        3'h3:    ea_class = `BFIST_EA_PCREL;
                        default: ea_class = `BFIST_EA_BAD;
                    endcase
                end
                default: ea_class = `BFIST_EA_BAD;
            endcase
        end
    endfunction

    // mapped register check, shared by reads and writes
    function addr_ok;
        input [AW-1:0] a;
        begin
            addr_ok = (a[1:0] == 2'h0) &&
                      ((a[7:0] <= `BFIST_EACL_OFS) ||
                       ((a[7:0] >= `BFIST_DREG_OFS) && (a[7:0] < 8'h60)));
        end
    endfunction

    // byte-lane merge of a write into an old value
    function [31:0] lanes;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer k;
        begin
            lanes = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k]) begin
                    lanes[k*8 +: 8] = nw[k*8 +: 8];
                end
            end
        end
    endfunction

    // decode of the instruction held in the word registers
    wire [1:0]  kind    = op_kind(opw[15:0]);
    wire [2:0]  eacl    = ea_class(opw[5:3], opw[2:0]);
    wire        is_ins  = (kind == 2'h1);
    wire        is_set  = (kind == 2'h2);
    wire        is_tst  = (kind == 2'h3);
    wire        is_dreg = (eacl == `BFIST_EA_DREG);
    wire [31:0] dst     = dreg[opw[2:0]];
    // source register only matters for insert
    wire [31:0] src     = dreg[extw[`BFIST_EXT_SRC_HI:`BFIST_EXT_SRC_LO]];

    // alterable classes for insert and set, pc relative only for test
    wire ea_ok = (eacl <= `BFIST_EA_ABSL) ||
                 ((eacl == `BFIST_EA_PCREL) && is_tst);
    wire legal = (kind != 2'h0) && ea_ok && !reserved_bad;

    // field origin: wraps in a data register, byte-aligned in memory
    wire [5:0]  start  = is_dreg ? {1'b0, offset[4:0]} : {3'h0, offset[2:0]};
    wire [63:0] window = is_dreg ? {dst, dst} : {oper_hi, oper_lo};
    wire [31:0] value  = is_set ? 32'hFFFFFFFF : src;

    bfist_spec bfist_spec_i (
        .ext          (extw[15:0]),
        .off_val      (dreg[extw[8:6]]),
        .wid_val      (dreg[extw[2:0]]),
        .offset       (offset),
        .width        (width),
        .reserved_bad (reserved_bad)
    );

    bfist_field bfist_field_i (
        .window   (window),
        .start    (start),
        .width    (width),
        .value    (value),
        .field_lj (field_lj),
        .value_lj (value_lj),
        .mask     (mask),
        .merged   (merged)
    );

    // flags source: inserted value for insert, old field otherwise
    wire [31:0] flag_src = is_ins ? value_lj : field_lj;
    wire [4:0]  next_ccr = {ccr[`BFIST_CC_X], flag_src[31],
                            (flag_src == 32'h00000000), 2'h0};

    // a wrapped register field may land in either half of the window
    wire [31:0] reg_mask = mask[63:32] | mask[31:0];
    wire [31:0] next_reg = (merged[63:32] & mask[63:32]) |
                           (merged[31:0] & mask[31:0]) |
                           (dst & ~reg_mask);

    // register write performs once address and data are both held
    wire wr_go = aw_got && w_got && !BVALID && (state == S_IDLE);
    wire [7:0] wa = waddr[7:0];

    // axi write address and data capture, either order
    always @(posedge MCLK) begin
        if (RST) begin
            AWREADY <= 1'b1;
            WREADY  <= 1'b1;
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            waddr   <= {AW{1'b0}};
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            BVALID  <= 1'b0;
            BRESP   <= `BFIST_RESP_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                AWREADY <= 1'b0;
                aw_got  <= 1'b1;
                waddr   <= AWADDR;
            end
            if (WVALID && WREADY) begin
                WREADY  <= 1'b0;
                w_got   <= 1'b1;
                wdata_q <= WDATA;
                wstrb_q <= WSTRB;
            end
            if (wr_go) begin
                aw_got <= 1'b0;
                w_got  <= 1'b0;
                BVALID <= 1'b1;
                BRESP  <= addr_ok(waddr) ? `BFIST_RESP_OKAY : `BFIST_RESP_SLVERR;
            end
            if (BVALID && BREADY) begin
                BVALID  <= 1'b0;
                AWREADY <= 1'b1;
                WREADY  <= 1'b1;
            end
        end
    end

    // axi read channel, data one cycle after the address is taken
    always @(posedge MCLK) begin
        if (RST) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= 32'h00000000;
            RRESP   <= `BFIST_RESP_OKAY;
        end else begin
            if (ARVALID && ARREADY) begin
                ARREADY <= 1'b0;
                RVALID  <= 1'b1;
                RRESP   <= addr_ok(ARADDR) ? `BFIST_RESP_OKAY : `BFIST_RESP_SLVERR;
                case (ARADDR[7:0])
                    `BFIST_STAT_OFS: RDATA <= {29'h00000000, ill, done, (state == S_EXEC)};
                    `BFIST_OPW_OFS:  RDATA <= opw;
                    `BFIST_EXT_OFS:  RDATA <= extw;
                    `BFIST_CCR_OFS:  RDATA <= {27'h0000000, ccr};
                    `BFIST_OPHI_OFS: RDATA <= oper_hi;
                    `BFIST_OPLO_OFS: RDATA <= oper_lo;
                    `BFIST_DISP_OFS: RDATA <= disp;
                    `BFIST_EACL_OFS: RDATA <= {29'h00000000, ea_last};
                    default: begin
                        if (addr_ok(ARADDR) && (ARADDR[7:0] >= `BFIST_DREG_OFS)) begin
                            RDATA <= dreg[ARADDR[4:2]];
                        end else begin
                            RDATA <= 32'h00000000;
                        end
                    end
                endcase
            end
            if (RVALID && RREADY) begin
                RVALID  <= 1'b0;
                ARREADY <= 1'b1;
            end
        end
    end

    // data registers: bus writes while idle, results after execution
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_dreg
            always @(posedge MCLK) begin
                if (RST) begin
                    dreg[g] <= `BFIST_RST_WORD;
                end else if (wr_go && (wa == (`BFIST_DREG_OFS + g * 4))) begin
                    dreg[g] <= lanes(dreg[g], wdata_q, wstrb_q);
                end else if ((state == S_EXEC) && legal && is_dreg && !is_tst &&
                             (opw[2:0] == g)) begin
                    dreg[g] <= next_reg;
                end
            end
        end
    endgenerate

    // sequencer, operand window, flags and status
    always @(posedge MCLK) begin
        if (RST) begin
            state   <= S_IDLE;
            opw     <= `BFIST_RST_WORD;
            extw    <= `BFIST_RST_WORD;
            ccr     <= `BFIST_RST_CCR;
            oper_hi <= `BFIST_RST_WORD;
            oper_lo <= `BFIST_RST_WORD;
            disp    <= `BFIST_RST_WORD;
            ea_last <= `BFIST_EA_DREG;
            done    <= 1'b0;
            ill     <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (wr_go) begin
                        case (wa)
                            `BFIST_CTRL_OFS: begin
                                if (wstrb_q[0] && wdata_q[`BFIST_CTRL_GO]) begin
                                    state <= S_EXEC;
                                end
                            end
                            `BFIST_STAT_OFS: begin
                                if (wstrb_q[0] && wdata_q[`BFIST_STAT_DONE]) begin
                                    done <= 1'b0;
                                end
                                if (wstrb_q[0] && wdata_q[`BFIST_STAT_ILL]) begin
                                    ill <= 1'b0;
                                end
                            end
                            `BFIST_OPW_OFS:  opw <= lanes(opw, wdata_q, wstrb_q);
                            `BFIST_EXT_OFS:  extw <= lanes(extw, wdata_q, wstrb_q);
                            `BFIST_CCR_OFS: begin
                                if (wstrb_q[0]) begin
                                    ccr <= wdata_q[4:0];
                                end
                            end
                            `BFIST_OPHI_OFS: oper_hi <= lanes(oper_hi, wdata_q, wstrb_q);
                            `BFIST_OPLO_OFS: oper_lo <= lanes(oper_lo, wdata_q, wstrb_q);
                            default: begin
                            end
                        endcase
                    end
                end
                S_EXEC: begin
                    state   <= S_IDLE;
                    done    <= 1'b1;
                    ea_last <= eacl;
                    if (legal) begin
                        ccr <= next_ccr;
                        // memory field starts at this signed byte displacement
                        disp <= is_dreg ? 32'h00000000 : {{3{offset[31]}}, offset[31:3]};
                        if (!is_dreg && !is_tst) begin
                            oper_hi <= merged[63:32];
                            oper_lo <= merged[31:0];
                        end
                    end else begin
                        ill <= 1'b1;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule

// ===== tb/bfist_core_monitor.sv
// checker of the bit-field unit register bus handshakes
// assumes: bound to bfist_core, sees its ports only
`timescale 1ns/1ps

module bfist_monitor #(
    parameter AW = 8
) (
    input wire          MCLK,
    input wire          RST,
    input wire [AW-1:0] AWADDR,
    input wire          AWVALID,
    input wire          AWREADY,
    input wire [31:0]   WDATA,
    input wire [3:0]    WSTRB,
    input wire          WVALID,
    input wire          WREADY,
    input wire [1:0]    BRESP,
    input wire          BVALID,
    input wire          BREADY,
    input wire [AW-1:0] ARADDR,
    input wire          ARVALID,
    input wire          ARREADY,
    input wire [31:0]   RDATA,
    input wire [1:0]    RRESP,
    input wire          RVALID,
    input wire          RREADY
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    // answers stand until taken, requests refused meanwhile
    a_bresp_stands: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    a_rdata_stands: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
        else $error("read data dropped early");
    a_write_refused: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write accepted while response pending");
    a_read_refused: assert property (RVALID |-> !ARREADY)
        else $error("read accepted while data pending");

    // answer timing after a take
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
        else $error("read not answered next cycle");
    a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID)
        else $error("write not answered in time");
    a_ready_return: assert property (BVALID && BREADY |=> !BVALID && AWREADY && WREADY)
        else $error("write channels not reopened");

    // read contents by address
    a_unmapped_read: assert property (ARVALID && ARREADY && ARADDR >= 8'h60 |=> RRESP == 2'h2 && RDATA == 32'h0)
        else $error("unmapped read not refused");
    a_flags_width: assert property (ARVALID && ARREADY && ARADDR == 8'h10 |=> RDATA[31:5] == 27'h0)
        else $error("flag register has stray bits");
    a_class_range: assert property (ARVALID && ARREADY && ARADDR == 8'h20 |=> RDATA[31:3] == 29'h0)
        else $error("location class out of range");

    // main traffic seen
    c_write: cover property (BVALID && BREADY);
    c_read: cover property (RVALID && RREADY);
    c_slverr: cover property (RVALID && RRESP == 2'h2);
endmodule

bind bfist_core bfist_monitor #(.AW(AW)) bfist_monitor_i (
    .MCLK(MCLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

// ===== tb/testbench.sv
// self-checking bench of the bit-field unit over its register bus
// assumes: bfist_core with the register map of bfist_map.vh
`timescale 1ns/1ps
`include "bfist_map.vh"

module testbench;
    reg         MCLK    = 1'h0;
    reg         RST     = 1'h1;
    reg  [7:0]  AWADDR  = 8'h00;
    reg         AWVALID = 1'h0;
    reg  [31:0] WDATA   = 32'h0;
    reg  [3:0]  WSTRB   = 4'hF;
    reg         WVALID  = 1'h0;
    reg         BREADY  = 1'h0;
    reg  [7:0]  ARADDR  = 8'h00;
    reg         ARVALID = 1'h0;
    reg         RREADY  = 1'h0;
    wire        AWREADY, WREADY, BVALID, ARREADY, RVALID;
    wire [1:0]  BRESP, RRESP;
    wire [31:0] RDATA;
    int         n_mismatch = 0;
    int         tests_run  = 0;
    reg  [31:0] v;
    reg  [1:0]  r;

    // 250 MHz clock
    always #2 MCLK = ~MCLK;

    bfist_core #(.AW(8)) bfist_core_i (
        .MCLK(MCLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

    // compare and count
    task automatic chk(input [31:0] seen, input [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one write; each channel released when taken
    task automatic wr(input [7:0] a, input [31:0] d);
        @(posedge MCLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        do begin
            @(posedge MCLK);
            if (AWVALID && AWREADY) AWVALID <= 1'h0;
            if (WVALID && WREADY) WVALID <= 1'h0;
        end while (!BVALID);
        BREADY <= 1'h0;
        r = BRESP;
    endtask

    // one read; data and response into v and r
    task automatic rd(input [7:0] a);
        @(posedge MCLK);
        ARADDR <= a;
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        do begin
            @(posedge MCLK);
            if (ARVALID && ARREADY) ARVALID <= 1'h0;
        end while (!RVALID);
        RREADY <= 1'h0;
        v = RDATA;
        r = RRESP;
    endtask

    function [7:0] dreg(input [2:0] k);
        dreg = `BFIST_DREG_OFS + {3'h0, k, 2'h0};
    endfunction

    // load words, start, poll status into v, then clear done and illegal
    task automatic run(input [9:0] op, input [5:0] ea, input [15:0] ext);
        wr(`BFIST_OPW_OFS, {16'h0, op, ea});
        wr(`BFIST_EXT_OFS, {16'h0, ext});
        wr(`BFIST_CTRL_OFS, 32'h1);
        // a unit that never finishes is left to the watchdog
        do begin
            rd(`BFIST_STAT_OFS);
        end while (v[`BFIST_STAT_DONE] !== 1'h1);
        wr(`BFIST_STAT_OFS, 32'h6);
    endtask

    // unmapped places answer with an error
    task automatic t_bus;
        rd(8'h80);
        chk(v, 32'h0);
        chk({30'h0, r}, 32'h2);
        wr(8'h60, 32'h1234);
        chk({30'h0, r}, 32'h2);
        $display("bus test done");
    endtask

    // byte 5A into a field of ones at offset 4; flags from the new byte, x kept
    task automatic t_insert;
        wr(dreg(1), 32'h00000F5A);
        wr(dreg(2), 32'hFFFFFFFF);
        wr(`BFIST_CCR_OFS, 32'h13);
        run(`BFIST_OPC_INS, 6'h02, 16'h1108);
        chk(v, 32'h2);
        rd(dreg(2));
        chk(v, 32'hF5AFFFFF);
        rd(`BFIST_CCR_OFS);
        chk(v, 32'h10);
        $display("insert test done");
    endtask

    // offset -4 and width 35 from registers; second pass sees the ones
    task automatic t_set;
        wr(dreg(3), 32'h0);
        wr(dreg(4), 32'hFFFFFFFC);
        wr(dreg(5), 32'h23);
        wr(`BFIST_CCR_OFS, 32'h1B);
        run(`BFIST_OPC_SET, 6'h03, 16'h0925);
        rd(dreg(3));
        chk(v, 32'h0000000E);
        rd(`BFIST_CCR_OFS);
        chk(v, 32'h14);
        run(`BFIST_OPC_SET, 6'h03, 16'h0925);
        rd(`BFIST_CCR_OFS);
        chk(v, 32'h18);
        $display("set test done");
    endtask

    // full width from offset 31, then a single zero bit; operand untouched
    task automatic t_test;
        wr(dreg(6), 32'h00000001);
        wr(`BFIST_CCR_OFS, 32'h0F);
        run(`BFIST_OPC_TST, 6'h06, 16'h77C0);
        chk(v, 32'h2);
        rd(`BFIST_CCR_OFS);
        chk(v, 32'h08);
        run(`BFIST_OPC_TST, 6'h06, 16'h0781);
        rd(`BFIST_CCR_OFS);
        chk(v, 32'h04);
        rd(dreg(6));
        chk(v, 32'h00000001);
        $display("test-only test done");
    endtask

    // refused locations, reserved bits and an unknown opcode flag illegal and keep the flags
    task automatic t_illegal;
        reg [31:0] tbl [0:7];
        tbl = '{{`BFIST_OPC_INS, 6'h3A, 16'h0008}, {`BFIST_OPC_SET, 6'h08, 16'h0008},
                {`BFIST_OPC_SET, 6'h18, 16'h0008}, {`BFIST_OPC_SET, 6'h20, 16'h0008},
                {`BFIST_OPC_SET, 6'h3C, 16'h0008}, {`BFIST_OPC_TST, 6'h00, 16'h0A00},
                {`BFIST_OPC_TST, 6'h00, 16'h0028}, {10'h3A7, 6'h00, 16'h0008}};
        wr(`BFIST_CCR_OFS, 32'h15);
        for (int i = 0; i < 8; i++) begin
            run(tbl[i][31:22], tbl[i][21:16], tbl[i][15:0]);
            chk(v, 32'h6);
            rd(`BFIST_CCR_OFS);
            chk(v, 32'h15);
        end
        $display("illegal test done");
    endtask

    // one legal location per class of the test operation and its class
    task automatic t_modes;
        reg [5:0] ea [0:6];
        ea = '{6'h00, 6'h10, 6'h28, 6'h30, 6'h38, 6'h39, 6'h3A};
        for (int i = 0; i < 7; i++) begin
            run(`BFIST_OPC_TST, ea[i], 16'h0008);
            chk(v, 32'h2);
            rd(`BFIST_EACL_OFS);
            chk(v, i);
        end
        $display("location test done");
    endtask

    // memory window: set at offset -12, then a 32-bit insert from offset 30 across both words
    task automatic t_memory;
        wr(dreg(7), 32'hFFFFFFF4);
        wr(`BFIST_OPHI_OFS, 32'h0F000000);
        wr(`BFIST_OPLO_OFS, 32'h0);
        wr(`BFIST_CCR_OFS, 32'h0);
        run(`BFIST_OPC_SET, 6'h10, 16'h09C8);
        rd(`BFIST_OPHI_OFS);
        chk(v, 32'h0FF00000);
        rd(`BFIST_DISP_OFS);
        chk(v, 32'hFFFFFFFE);
        rd(`BFIST_CCR_OFS);
        chk(v, 32'h08);
        run(`BFIST_OPC_INS, 6'h38, 16'h1780);
        rd(`BFIST_OPHI_OFS);
        chk(v, 32'h0C00003D);
        rd(`BFIST_OPLO_OFS);
        chk(v, 32'h68000000);
        rd(`BFIST_DISP_OFS);
        chk(v, 32'h3);
        rd(`BFIST_CCR_OFS);
        chk(v, 32'h0);
        $display("memory test done");
    endtask

    // verdict and end of run
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // reset, then the scenarios
    initial begin
        repeat (8) @(posedge MCLK);
        RST <= 1'h0;
        t_bus;
        t_insert;
        t_set;
        t_test;
        t_illegal;
        t_modes;
        t_memory;
        finish_test;
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge MCLK);
        n_mismatch++;
        finish_test;
    end
endmodule
